// File: dpl_defines.svh
// Register offsets, field positions, reset values and widths of the loop control bank
`ifndef DPL_DEFINES_SVH
`define DPL_DEFINES_SVH

`define DPL_ADDR_W 16
`define DPL_DATA_W 8
`define DPL_STEP_W 16
`define DPL_OFS_W 24

`define DPL_OFF_USER_MODE 16'h0a22
`define DPL_OFF_RESET_CTRL 16'h0a23
`define DPL_OFF_PHASE_CTRL 16'h0a24
`define DPL_OFF_STATUS 16'h0a28
`define DPL_OFF_OFS_LO 16'h0a29
`define DPL_OFF_OFS_MID 16'h0a2a
`define DPL_OFF_OFS_HI 16'h0a2b

`define DPL_MANREF_HI 6
`define DPL_MANREF_LO 5
`define DPL_SWMODE_HI 4
`define DPL_SWMODE_LO 2
`define DPL_HOLDOVER_BIT 1
`define DPL_FREERUN_BIT 0

`define DPL_LF_RST_BIT 2
`define DPL_HIST_CLR_BIT 1
`define DPL_AUTOSYNC_RST_BIT 0

`define DPL_PH_ZERO_BIT 2
`define DPL_PH_DEC_BIT 1
`define DPL_PH_INC_BIT 0

`define DPL_MANREF_RST 2'h0
`define DPL_SWMODE_RST 3'h0
`define DPL_SWMODE_LAST 3'h4
`define DPL_USER_BIT_RST 1'h0
`define DPL_RDATA_RST 8'h00

`endif

// File: dpl_pkg.sv
// Types shared by the loop control bank modules
package dpl_pkg;

  // Gray order: normal -> holdover -> free run
  typedef enum logic [1:0] {
    DPL_LOOP_NORMAL = 2'b00,
    DPL_LOOP_HOLDOVER = 2'b01,
    DPL_LOOP_FREERUN = 2'b11
  } dpl_loop_state_type;

  typedef enum logic [2:0] {
    DPL_SW_AUTO_REVERT = 3'h0,
    DPL_SW_AUTO_NONREVERT = 3'h1,
    DPL_SW_MAN_AUTO_FALLBACK = 3'h2,
    DPL_SW_MAN_HOLD_FALLBACK = 3'h3,
    DPL_SW_MAN_NO_FALLBACK = 3'h4
  } dpl_switch_mode_type;

endpackage

// File: dpl_phase_if.sv
// Command and result signals between the bank and its phase offset accumulator
`timescale 1ns/1ps
`include "dpl_defines.svh"

interface dpl_phase_if;
  logic zero;
  logic dec;
  logic inc;
  logic [`DPL_STEP_W-1:0] step;
  logic [`DPL_OFS_W-1:0] offset;

  modport ctrl (
    output zero,
    output dec,
    output inc,
    output step,
    input offset
  );

  modport acc (
    input zero,
    input dec,
    input inc,
    input step,
    output offset
  );
endinterface

// File: dpl_phase_acc.sv
// Incremental phase offset accumulator
`timescale 1ns/1ps
`include "dpl_defines.svh"

module dpl_phase_acc
  import dpl_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  dpl_phase_if.acc ph
);

  logic [`DPL_OFS_W-1:0] offset_reg;
  logic [`DPL_OFS_W-1:0] offset_next;
  logic [`DPL_OFS_W-1:0] step_ext;

  assign step_ext = {{(`DPL_OFS_W-`DPL_STEP_W){1'b0}}, ph.step};

  // Zero wins; increment and decrement together cancel
  always_comb
  begin
    offset_next = offset_reg;
    if (ph.zero)
    begin
      offset_next = '0;
    end
    else if (ph.inc && !ph.dec)
    begin
      offset_next = offset_reg + step_ext;
    end
    else if (ph.dec && !ph.inc)
    begin
      offset_next = offset_reg - step_ext;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      offset_reg <= '0;
    end
    else
    begin
      offset_reg <= offset_next;
    end
  end

  assign ph.offset = offset_reg;

endmodule

// File: dpl_loop_ctrl.sv
// User mode, reset and phase control bank for one digital loop
`timescale 1ns/1ps
`include "dpl_defines.svh"


module dpl_loop_ctrl
  import dpl_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [`DPL_ADDR_W-1:0] reg_addr,
  input wire logic [`DPL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DPL_DATA_W-1:0] reg_rdata,
  input wire logic history_available,
  input wire logic [`DPL_STEP_W-1:0] phase_step,
  output logic [1:0] manual_ref,
  output logic [2:0] switch_mode,
  output logic switch_mode_valid,
  output dpl_loop_state_type loop_state,
  output logic loop_filter_rst,
  output logic history_clr,
  output logic autosync_rst,
  output logic [`DPL_OFS_W-1:0] phase_offset
);

  // ==========================================================
  // Address decode
  function automatic logic hit(input logic [`DPL_ADDR_W-1:0] a,
                               input logic [`DPL_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  logic wr_mode;
  logic wr_reset;
  logic wr_phase;

  assign wr_mode = reg_wr && hit(reg_addr, `DPL_OFF_USER_MODE);
  assign wr_reset = reg_wr && hit(reg_addr, `DPL_OFF_RESET_CTRL);
  assign wr_phase = reg_wr && hit(reg_addr, `DPL_OFF_PHASE_CTRL);

  // ==========================================================
  // User mode register
  logic [1:0] manual_ref_reg;
  logic [2:0] switch_mode_reg;
  logic user_holdover_reg;
  logic user_freerun_reg;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      manual_ref_reg <= `DPL_MANREF_RST;
      switch_mode_reg <= `DPL_SWMODE_RST;
      user_holdover_reg <= `DPL_USER_BIT_RST;
      user_freerun_reg <= `DPL_USER_BIT_RST;
    end
    else if (wr_mode)
    begin
      manual_ref_reg <= reg_wdata[`DPL_MANREF_HI:`DPL_MANREF_LO];
      switch_mode_reg <= reg_wdata[`DPL_SWMODE_HI:`DPL_SWMODE_LO];
      user_holdover_reg <= reg_wdata[`DPL_HOLDOVER_BIT];
      user_freerun_reg <= reg_wdata[`DPL_FREERUN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      manual_ref <= `DPL_MANREF_RST;
      switch_mode <= `DPL_SWMODE_RST;
      switch_mode_valid <= 1'b1;
    end
    else
    begin
      manual_ref <= manual_ref_reg;
      switch_mode <= switch_mode_reg;
      switch_mode_valid <= (switch_mode_reg <= `DPL_SWMODE_LAST);
    end
  end

  // ==========================================================
  // Loop operating state
  dpl_loop_state_type state_next;

  // Free run outranks holdover
  always_comb
  begin
    state_next = DPL_LOOP_NORMAL;
    if (user_freerun_reg)
    begin
      state_next = DPL_LOOP_FREERUN;
    end
    else if (user_holdover_reg)
    begin
      if (history_available)
      begin
        state_next = DPL_LOOP_HOLDOVER;
      end
      else
      begin
        state_next = DPL_LOOP_FREERUN;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loop_state <= DPL_LOOP_NORMAL;
    end
    else
    begin
      loop_state <= state_next;
    end
  end

  // ==========================================================
  // Autoclearing reset strobes, one cycle per write of one
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loop_filter_rst <= 1'b0;
      history_clr <= 1'b0;
      autosync_rst <= 1'b0;
    end
    else
    begin
      loop_filter_rst <= wr_reset && reg_wdata[`DPL_LF_RST_BIT];
      history_clr <= wr_reset && reg_wdata[`DPL_HIST_CLR_BIT];
      autosync_rst <= wr_reset && reg_wdata[`DPL_AUTOSYNC_RST_BIT];
    end
  end

  // ==========================================================
  // Phase offset accumulator
  dpl_phase_if ph ();

  assign ph.zero = wr_phase && reg_wdata[`DPL_PH_ZERO_BIT];
  assign ph.dec = wr_phase && reg_wdata[`DPL_PH_DEC_BIT];
  assign ph.inc = wr_phase && reg_wdata[`DPL_PH_INC_BIT];
  assign ph.step = phase_step;

  dpl_phase_acc u_acc (
    .mclk(mclk),
    .arst_n(arst_n),
    .ph(ph.acc)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase_offset <= '0;
    end
    else
    begin
      phase_offset <= ph.offset;
    end
  end

  // ==========================================================
  // Read back; control registers read zero
  logic [`DPL_DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = `DPL_RDATA_RST;
    unique case (reg_addr)
      `DPL_OFF_USER_MODE:
        rd_mux = {1'b0, manual_ref_reg, switch_mode_reg, user_holdover_reg,
                  user_freerun_reg};
      `DPL_OFF_RESET_CTRL:
        rd_mux = 8'h00;
      `DPL_OFF_PHASE_CTRL:
        rd_mux = 8'h00;
      `DPL_OFF_STATUS:
        rd_mux = {5'h00, history_available, loop_state};
      `DPL_OFF_OFS_LO:
        rd_mux = ph.offset[7:0];
      `DPL_OFF_OFS_MID:
        rd_mux = ph.offset[15:8];
      `DPL_OFF_OFS_HI:
        rd_mux = ph.offset[23:16];
      default:
        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= `DPL_RDATA_RST;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rd_mux;
    end
    else
    begin
      reg_rdata <= `DPL_RDATA_RST;
    end
  end

endmodule

// File: dpl_loop_ctrl_properties.sv
// Port checks for the loop control bank
`timescale 1ns/1ps
`include "dpl_defines.svh"
module dpl_loop_ctrl_properties
  import dpl_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [`DPL_ADDR_W-1:0] reg_addr,
  input wire logic [`DPL_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`DPL_DATA_W-1:0] reg_rdata,
  input wire logic history_available,
  input wire logic [2:0] switch_mode,
  input wire logic switch_mode_valid,
  input wire dpl_loop_state_type loop_state,
  input wire logic loop_filter_rst,
  input wire logic history_clr,
  input wire logic autosync_rst
);
  logic rw;
  assign rw = reg_wr && reg_addr == `DPL_OFF_RESET_CTRL;
  // ====
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_mode_wr(logic [1:0] m);
    reg_wr && reg_addr == `DPL_OFF_USER_MODE && reg_wdata[1:0] == m;
  endsequence
  sequence s_hist(logic h);
    history_available == h ##1 !reg_wr && history_available == h;
  endsequence
  a_lf_pulse: assert property (loop_filter_rst == $past(rw && reg_wdata[2]))
    else $error("lf pulse");
  a_hist_pulse: assert property (history_clr == $past(rw && reg_wdata[1]))
    else $error("hist pulse");
  a_sync_pulse: assert property (autosync_rst == $past(rw && reg_wdata[0]))
    else $error("sync pulse");
  a_mode_valid: assert property (switch_mode_valid == (switch_mode <= `DPL_SWMODE_LAST))
    else $error("mode valid");
  a_freerun_forced: assert property (
    s_mode_wr(2'b01) ##1 !reg_wr |=> loop_state == DPL_LOOP_FREERUN) else $error("free run");
  a_holdover_forced: assert property (
    s_mode_wr(2'b10) ##0 s_hist(1'b1) |=> loop_state == DPL_LOOP_HOLDOVER) else $error("hold");
  a_hold_no_history: assert property (
    s_mode_wr(2'b10) ##0 s_hist(1'b0) |=> loop_state == DPL_LOOP_FREERUN) else $error("no hist");
  a_ctl_read_zero: assert property (
    reg_rd && reg_addr inside {`DPL_OFF_RESET_CTRL, `DPL_OFF_PHASE_CTRL} |=> reg_rdata == 8'h00)
    else $error("ctl read");
endmodule

bind dpl_loop_ctrl dpl_loop_ctrl_properties u_props (.mclk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .history_available, .switch_mode, .switch_mode_valid,
  .loop_state, .loop_filter_rst, .history_clr, .autosync_rst);

// File: tb.sv
// Self-checking bench for the loop control bank
`timescale 1ns/1ps
`include "dpl_defines.svh"
module tb
  import dpl_pkg::*;
;
  logic mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, history_available = 1'b0;
  logic [15:0] reg_addr = 16'h0000, phase_step = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [1:0] manual_ref;
  logic [2:0] switch_mode;
  logic switch_mode_valid, loop_filter_rst, history_clr, autosync_rst;
  dpl_loop_state_type loop_state;
  logic [23:0] phase_offset;
  int miscompares = 0, n_tests = 0;
  dpl_loop_ctrl dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .history_available, .phase_step, .manual_ref, .switch_mode, .switch_mode_valid,
    .loop_state, .loop_filter_rst, .history_clr, .autosync_rst, .phase_offset);
  always #10 mclk = ~mclk;
  // ====
  // Bus and compare tasks
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string name);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(24'(reg_rdata), 24'(exp), name);
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====
  // Scenarios
  task automatic t_reset();
    @(posedge mclk);
    #1;
    chk(24'(loop_state), 24'(DPL_LOOP_NORMAL), "state");
    chk(24'(switch_mode_valid), 24'h000001, "valid");
    rd(`DPL_OFF_USER_MODE, 8'h00, "mode reset");
    wr(16'h0a30, 8'hff);
    rd(16'h0a30, 8'h00, "unmapped");
  endtask
  task automatic t_modes();
    logic [7:0] v;
    for (int i = 0; i < 8; i++)
    begin
      v = {1'b0, 2'(i), 3'(i), 2'b00};
      wr(`DPL_OFF_USER_MODE, v);
      rd(`DPL_OFF_USER_MODE, v, "mode rd");
      settle();
      chk(24'(manual_ref), 24'(i % 4), "ref");
      chk(24'(switch_mode), 24'(i), "mode");
      chk(24'(switch_mode_valid), 24'(i < 5), "mvalid");
    end
  endtask
  task automatic t_hold();
    logic [7:0] wv [5] = '{8'h02, 8'h02, 8'h00, 8'h01, 8'h03};
    logic [4:0] hv = 5'b11101;
    dpl_loop_state_type sv [5] = '{DPL_LOOP_HOLDOVER, DPL_LOOP_FREERUN, DPL_LOOP_NORMAL,
      DPL_LOOP_FREERUN, DPL_LOOP_FREERUN};
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk);
      history_available <= hv[i];
      wr(`DPL_OFF_USER_MODE, wv[i]);
      settle();
      chk(24'(loop_state), 24'(sv[i]), "loop");
      rd(`DPL_OFF_STATUS, {5'h00, hv[i], sv[i]}, "status");
    end
  endtask
  task automatic t_strobes();
    for (int b = 0; b < 4; b++)
    begin
      wr(`DPL_OFF_RESET_CTRL, 8'(b < 3 ? 1 << b : 0));
      #1;
      chk(24'({loop_filter_rst, history_clr, autosync_rst}), 24'(b < 3 ? 1 << b : 0), "pulse");
      @(posedge mclk);
      #1;
      chk(24'({loop_filter_rst, history_clr, autosync_rst}), 24'h000000, "pulse end");
      rd(`DPL_OFF_RESET_CTRL, 8'h00, "rst rd");
    end
  endtask
  task automatic t_phase();
    logic [7:0] op [6] = '{8'h01, 8'h01, 8'h02, 8'h02, 8'h02, 8'h04};
    logic [23:0] ex [6] = '{24'h000010, 24'h000020, 24'h000010, 24'h000000, 24'hfffff0,
      24'h000000};
    @(posedge mclk);
    phase_step <= 16'h0010;
    for (int i = 0; i < 6; i++)
    begin
      wr(`DPL_OFF_PHASE_CTRL, op[i]);
      settle();
      chk(phase_offset, ex[i], "offset");
      rd(`DPL_OFF_OFS_LO, ex[i][7:0], "ofs lo");
      rd(`DPL_OFF_OFS_HI, ex[i][23:16], "ofs hi");
    end
    rd(`DPL_OFF_PHASE_CTRL, 8'h00, "ph rd");
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_modes();
    t_hold();
    t_strobes();
    t_phase();
    report_and_stop();
  end
  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    report_and_stop();
  end
endmodule
